// [src/pfd_pkg.sv]
// shared constants for the port function and direction control block
package pfd_pkg;
  // register addresses on the special-function port
  localparam logic [7:0] ADDR_P0_DATA = 8'h80; // port 0 data latch
  localparam logic [7:0] ADDR_P0_INPUT_MODE = 8'h8f;
  localparam logic [7:0] ADDR_P1_DATA = 8'h90; // port 1 data latch
  localparam logic [7:0] ADDR_P2_DATA = 8'ha0; // port 2 data latch
  localparam logic [7:0] ADDR_LOC_CFG = 8'hf1; // peripheral location config
  localparam logic [7:0] ADDR_P1_SEL = 8'hf4;
  localparam logic [7:0] ADDR_P2_SEL = 8'hf5;
  localparam logic [7:0] ADDR_PULL_CFG = 8'hf7; // pull polarity register
  localparam logic [7:0] ADDR_P0_DIR = 8'hfd;
  localparam logic [7:0] ADDR_P1_DIR = 8'hfe;
  localparam logic [7:0] ADDR_P2_DIR = 8'hff;
  // field positions in the port 2 select register
  localparam int SER_PAIR_BIT = 6;
  localparam int SER1_T3_BIT = 5;
  localparam int T1_T4_BIT = 4;
  localparam int SER0_T1_BIT = 3;
  localparam int P2_PIN4_FN_BIT = 2;
  localparam int P2_PIN3_FN_BIT = 1;
  localparam int P2_PIN0_FN_BIT = 0;
  // field positions elsewhere
  localparam int PREC_HI_BIT = 7; // port 0 precedence field, upper bit
  localparam int PREC_LO_BIT = 6;
  localparam int PULL_POL_BIT = 5; // port 0 pull polarity
  localparam int DBG_DATA_PIN = 1; // port 2 pin carrying debug data
  localparam int DBG_CLK_PIN = 2; // port 2 pin carrying debug clock
  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_P2_SEL = 8'h7f;
  localparam logic [7:0] MASK_P2_DIR = 8'hdf;
  localparam logic [7:0] MASK_LOC_CFG = 8'h73;
  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [4:0] RST_P2_DATA = 5'h1f;
  // peripheral slots in the packed claim, out and enable vectors
  localparam int PER_SER0 = 0;
  localparam int PER_SER1 = 1;
  localparam int PER_TMR1 = 2;
  localparam int PER_TMR3 = 3;
  localparam int PER_TMR4 = 4;
  localparam int P0_NPER = 3;
  localparam int P1_NPER = 5;
  // port 0 precedence modes
  typedef enum logic [1:0] {
    PREC_SER0_SER1 = 2'b00,
    PREC_SER1_SER0 = 2'b01,
    PREC_TMR1A_SER1 = 2'b10,
    PREC_TMR1B_SER0 = 2'b11
  } pfd_prec_e;
endpackage

// [src/pfd_top.sv]
// port function select, direction, precedence and pad drive logic
//
// Operation
// - port 1 select bit: 0 gpio, 1 peripheral
// - serial pair on port 1: bit 6 picks
// - serial 1 versus timer 3: bit 5 picks
// - timer 1 versus timer 4: bit 4 picks
// - serial 0 versus timer 1: bit 3 picks
// - port 2 pins 4,3,0 function bits
// - port 0 direction bits, reset all inputs
// - port 1 direction bits, reset all inputs
// - port 2 direction bits 4:0, bit 5 zero
// - port 0 precedence field in bits 7:6
// - port 0 input mode: pull or tristate
// - one port 0 bit: pull-up or pull-down
// - debug overrides port 2 pins 1 and 2
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pfd_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] p0_pad_in,
  input wire logic [7:0] p1_pad_in,
  input wire logic [4:0] p2_pad_in,
  output logic [7:0] p0_pad_out,
  output logic [7:0] p0_pad_oe,
  output logic [7:0] p1_pad_out,
  output logic [7:0] p1_pad_oe,
  output logic [4:0] p2_pad_out,
  output logic [4:0] p2_pad_oe,
  output logic [7:0] p0_pull_en,
  output logic p0_pull_down,
  output logic [7:0] p0_pin_level,
  output logic [7:0] p1_pin_level,
  output logic [4:0] p2_pin_level,
  output logic [7:0] peripheral_location_config,
  input wire logic [23:0] p0_per_claim,
  input wire logic [23:0] p0_per_out,
  input wire logic [23:0] p0_per_oe,
  input wire logic [39:0] p1_per_claim,
  input wire logic [39:0] p1_per_out,
  input wire logic [39:0] p1_per_oe,
  input wire logic [4:0] p2_per_out,
  input wire logic [4:0] p2_per_oe,
  input wire logic dbg_active,
  input wire logic dbg_drive,
  input wire logic dbg_data_out
);

  // every flip-flop of the block lives in this one struct
  typedef struct packed {
    logic [7:0] p0_data; // port data latches
    logic [7:0] p1_data;
    logic [4:0] p2_data;
    logic [7:0] p0_mode; // port0_input_mode
    logic [7:0] loc_cfg; // peripheral_location_config
    logic [7:0] p1_sel; // port1_function_select
    logic [7:0] p2_sel; // port2_function_and_priority
    logic pull_pol; // port0_pull_polarity
    logic [7:0] p0_dir; // port0_direction
    logic [7:0] p1_dir; // port1_direction
    logic [7:0] p2_dir; // port2_direction_and_priority
    logic [20:0] sync1; // pin synchroniser, three stages
    logic [20:0] sync2;
    logic [20:0] sync3;
    logic [20:0] filt; // settled pin levels
    logic [7:0] rdata;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic [4:0] p2_out;
    logic [4:0] p2_oe;
    logic [7:0] p0_pull_en;
  } pfd_state_s;

  pfd_state_s st_ff; // registered state
  pfd_state_s nxt_st; // next state

  // per-pin winner and resulting pad values
  logic [7:0] p0_pin_out;
  logic [7:0] p0_pin_oe;
  logic [7:0] p1_pin_out;
  logic [7:0] p1_pin_oe;
  logic [4:0] p2_fn; // port 2 per-pin function select
  logic [2:0] p0_win [8];
  logic [4:0] p1_win [8];

  // port 1 contest: pairwise drops, then lowest slot left wins
  // three-way clashes that stay open are software's to avoid
  function automatic logic [4:0] pfd_p1_pick(input logic [4:0] c, input logic [3:0] pri);
    logic [4:0] r;
    r = c;
    if (r[pfd_pkg::PER_SER0] && r[pfd_pkg::PER_SER1]) begin
      if (pri[3]) r[pfd_pkg::PER_SER0] = 1'b0;
      else r[pfd_pkg::PER_SER1] = 1'b0;
    end
    if (r[pfd_pkg::PER_SER1] && r[pfd_pkg::PER_TMR3]) begin
      if (pri[2]) r[pfd_pkg::PER_SER1] = 1'b0;
      else r[pfd_pkg::PER_TMR3] = 1'b0;
    end
    if (r[pfd_pkg::PER_TMR1] && r[pfd_pkg::PER_TMR4]) begin
      if (pri[1]) r[pfd_pkg::PER_TMR1] = 1'b0;
      else r[pfd_pkg::PER_TMR4] = 1'b0;
    end
    if (r[pfd_pkg::PER_SER0] && r[pfd_pkg::PER_TMR1]) begin
      if (pri[0]) r[pfd_pkg::PER_SER0] = 1'b0;
      else r[pfd_pkg::PER_TMR1] = 1'b0;
    end
    return r & (~r + 5'h01); // keep one claimant only
  endfunction

  // port 0 contest steered by the two-bit precedence field
  function automatic logic [2:0] pfd_p0_pick(input logic [2:0] c, input pfd_pkg::pfd_prec_e m);
    logic [2:0] r;
    r = c;
    case (m)
      pfd_pkg::PREC_SER0_SER1: if (r[0] && r[1]) r[1] = 1'b0;
      pfd_pkg::PREC_SER1_SER0: if (r[0] && r[1]) r[0] = 1'b0;
      pfd_pkg::PREC_TMR1A_SER1: if (r[2] && r[1]) r[1] = 1'b0;
      pfd_pkg::PREC_TMR1B_SER0: if (r[2] && r[0]) r[0] = 1'b0;
      default: r = c;
    endcase
    return r & (~r + 3'h1);
  endfunction

  // one slice per pin: gather columns, pick winner, form pad value
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      logic [2:0] c0;
      logic [2:0] o0;
      logic [2:0] e0;
      logic [4:0] c1;
      logic [4:0] o1;
      logic [4:0] e1;
      assign c0 = {p0_per_claim[16+gi], p0_per_claim[8+gi], p0_per_claim[gi]};
      assign o0 = {p0_per_out[16+gi], p0_per_out[8+gi], p0_per_out[gi]};
      assign e0 = {p0_per_oe[16+gi], p0_per_oe[8+gi], p0_per_oe[gi]};
      assign c1 = {p1_per_claim[32+gi], p1_per_claim[24+gi], p1_per_claim[16+gi],
                   p1_per_claim[8+gi], p1_per_claim[gi]};
      assign o1 = {p1_per_out[32+gi], p1_per_out[24+gi], p1_per_out[16+gi],
                   p1_per_out[8+gi], p1_per_out[gi]};
      assign e1 = {p1_per_oe[32+gi], p1_per_oe[24+gi], p1_per_oe[16+gi],
                   p1_per_oe[8+gi], p1_per_oe[gi]};
      assign p0_win[gi] = pfd_p0_pick(c0, pfd_pkg::pfd_prec_e'(st_ff.p2_dir[7:6]));
      assign p1_win[gi] = pfd_p1_pick(c1, st_ff.p2_sel[6:3]);
      // port 0 pins are always peripheral-capable through claims; gpio else
      assign p0_pin_oe[gi] = (|p0_win[gi]) ? |(p0_win[gi] & e0) : st_ff.p0_dir[gi];
      assign p0_pin_out[gi] = (|p0_win[gi]) ? |(p0_win[gi] & o0) : st_ff.p0_data[gi];
      // port 1: select bit chooses peripheral or gpio
      assign p1_pin_oe[gi] = st_ff.p1_sel[gi] ? |(p1_win[gi] & e1) : st_ff.p1_dir[gi];
      assign p1_pin_out[gi] = st_ff.p1_sel[gi] ? |(p1_win[gi] & o1) : st_ff.p1_data[gi];
    end
  endgenerate

  // port 2 function bits sit at pins 4, 3 and 0 only
  assign p2_fn = {st_ff.p2_sel[2], st_ff.p2_sel[1], 2'b00, st_ff.p2_sel[0]};

  // next-state logic: register writes, reads, pins, pads
  always_comb begin
    logic [20:0] pins;
    logic [7:0] rd_val;
    pins = {p2_pad_in, p1_pad_in, p0_pad_in};
    rd_val = 8'h00;
    nxt_st = st_ff;
    // three-stage synchroniser; a change counts once stages 2 and 3 agree
    nxt_st.sync1 = pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.filt = (~(st_ff.sync2 ^ st_ff.sync3) & st_ff.sync3)
                | ((st_ff.sync2 ^ st_ff.sync3) & st_ff.filt);
    // register writes; unmapped addresses are ignored
    if (reg_wr) begin
      case (reg_addr)
        pfd_pkg::ADDR_P0_DATA: nxt_st.p0_data = reg_wdata;
        pfd_pkg::ADDR_P1_DATA: nxt_st.p1_data = reg_wdata;
        pfd_pkg::ADDR_P2_DATA: nxt_st.p2_data = reg_wdata[4:0];
        pfd_pkg::ADDR_P0_INPUT_MODE: nxt_st.p0_mode = reg_wdata;
        pfd_pkg::ADDR_LOC_CFG: nxt_st.loc_cfg = reg_wdata & pfd_pkg::MASK_LOC_CFG;
        pfd_pkg::ADDR_P1_SEL: nxt_st.p1_sel = reg_wdata;
        pfd_pkg::ADDR_P2_SEL: nxt_st.p2_sel = reg_wdata & pfd_pkg::MASK_P2_SEL;
        pfd_pkg::ADDR_PULL_CFG: nxt_st.pull_pol = reg_wdata[pfd_pkg::PULL_POL_BIT];
        pfd_pkg::ADDR_P0_DIR: nxt_st.p0_dir = reg_wdata;
        pfd_pkg::ADDR_P1_DIR: nxt_st.p1_dir = reg_wdata;
        pfd_pkg::ADDR_P2_DIR: nxt_st.p2_dir = reg_wdata & pfd_pkg::MASK_P2_DIR;
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
    // read mux; outputs show latch, inputs show the settled pin level
    case (reg_addr)
      pfd_pkg::ADDR_P0_DATA:
        rd_val = (st_ff.p0_dir & st_ff.p0_data) | (~st_ff.p0_dir & st_ff.filt[7:0]);
      pfd_pkg::ADDR_P1_DATA:
        rd_val = (st_ff.p1_dir & st_ff.p1_data) | (~st_ff.p1_dir & st_ff.filt[15:8]);
      pfd_pkg::ADDR_P2_DATA:
        rd_val = {3'b000, (st_ff.p2_dir[4:0] & st_ff.p2_data)
                        | (~st_ff.p2_dir[4:0] & st_ff.filt[20:16])};
      pfd_pkg::ADDR_P0_INPUT_MODE: rd_val = st_ff.p0_mode;
      pfd_pkg::ADDR_LOC_CFG: rd_val = st_ff.loc_cfg;
      pfd_pkg::ADDR_P1_SEL: rd_val = st_ff.p1_sel;
      pfd_pkg::ADDR_P2_SEL: rd_val = st_ff.p2_sel;
      pfd_pkg::ADDR_PULL_CFG: rd_val = {2'b00, st_ff.pull_pol, 5'h00};
      pfd_pkg::ADDR_P0_DIR: rd_val = st_ff.p0_dir;
      pfd_pkg::ADDR_P1_DIR: rd_val = st_ff.p1_dir;
      pfd_pkg::ADDR_P2_DIR: rd_val = st_ff.p2_dir;
      default: rd_val = 8'h00; // unmapped reads answer zero
    endcase
    // read data stands only in the cycle after the strobe
    nxt_st.rdata = reg_rd ? rd_val : 8'h00;
    // pad values, registered so outputs come from flops
    nxt_st.p0_out = p0_pin_out;
    nxt_st.p0_oe = p0_pin_oe;
    nxt_st.p1_out = p1_pin_out;
    nxt_st.p1_oe = p1_pin_oe;
    nxt_st.p2_out = (p2_fn & p2_per_out) | (~p2_fn & st_ff.p2_data);
    nxt_st.p2_oe = (p2_fn & p2_per_oe) | (~p2_fn & st_ff.p2_dir[4:0]);
    // debug owns its two pins; drives data pin only when answering the host
    if (dbg_active) begin
      nxt_st.p2_oe[pfd_pkg::DBG_CLK_PIN] = 1'b0;
      nxt_st.p2_oe[pfd_pkg::DBG_DATA_PIN] = dbg_drive;
      nxt_st.p2_out[pfd_pkg::DBG_DATA_PIN] = dbg_data_out;
    end
    // pull only on port 0 inputs in pull mode; a driven pin needs none
    nxt_st.p0_pull_en = ~st_ff.p0_mode & ~p0_pin_oe;
    // synchronous reset last so it wins over everything above
    if (rst) begin
      nxt_st = '0;
      nxt_st.p0_data = pfd_pkg::RST_DATA;
      nxt_st.p1_data = pfd_pkg::RST_DATA;
      nxt_st.p2_data = pfd_pkg::RST_P2_DATA;
      nxt_st.p0_mode = pfd_pkg::RST_ZERO;
      nxt_st.p1_sel = pfd_pkg::RST_ZERO;
      nxt_st.p0_dir = pfd_pkg::RST_ZERO;
      nxt_st.p1_dir = pfd_pkg::RST_ZERO;
    end
  end

  // the single state register
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  // outputs straight from the state flops
  assign reg_rdata = st_ff.rdata;
  assign p0_pad_out = st_ff.p0_out;
  assign p0_pad_oe = st_ff.p0_oe;
  assign p1_pad_out = st_ff.p1_out;
  assign p1_pad_oe = st_ff.p1_oe;
  assign p2_pad_out = st_ff.p2_out;
  assign p2_pad_oe = st_ff.p2_oe;
  assign p0_pull_en = st_ff.p0_pull_en;
  assign p0_pull_down = st_ff.pull_pol;
  assign p0_pin_level = st_ff.filt[7:0];
  assign p1_pin_level = st_ff.filt[15:8];
  assign p2_pin_level = st_ff.filt[20:16];
  assign peripheral_location_config = st_ff.loc_cfg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sel_reset_a: assert property ($fell(rst) |-> st_ff.p1_sel == 8'h00)
    else $error("port 1 select not cleared by reset");
  sel_read_a: assert property (reg_rd && reg_addr == pfd_pkg::ADDR_P1_SEL && !reg_wr
      |=> reg_rdata == $past(st_ff.p1_sel))
    else $error("port 1 select readback wrong");
  ser_pair_a: assert property (st_ff.p1_sel[0] && p1_per_claim[0] && p1_per_claim[8]
      && !p1_per_claim[16] && !p1_per_claim[24] && !st_ff.p2_sel[6]
      |=> p1_pad_out[0] == $past(p1_per_out[0]))
    else $error("serial pair precedence wrong");
  ser1_t3_a: assert property (st_ff.p1_sel[1] && p1_per_claim[9] && p1_per_claim[25]
      && !p1_per_claim[1] && !p1_per_claim[17] && st_ff.p2_sel[5]
      |=> p1_pad_oe[1] == $past(p1_per_oe[25]))
    else $error("timer 3 precedence wrong");
  t1_t4_a: assert property (st_ff.p1_sel[2] && p1_per_claim[18] && p1_per_claim[34]
      && !p1_per_claim[2] && !p1_per_claim[10] && !p1_per_claim[26] && st_ff.p2_sel[4]
      |=> p1_pad_out[2] == $past(p1_per_out[34]))
    else $error("timer 4 precedence wrong");
  s0_t1_a: assert property (st_ff.p1_sel[3] && p1_per_claim[3] && p1_per_claim[19]
      && !p1_per_claim[11] && !p1_per_claim[35] && !st_ff.p2_sel[3]
      |=> p1_pad_out[3] == $past(p1_per_out[3]))
    else $error("serial 0 over timer 1 wrong");
  p2_fn_a: assert property (st_ff.p2_sel[2] |=> p2_pad_oe[4] == $past(p2_per_oe[4]))
    else $error("port 2 pin 4 function wrong");
  p0_gpio_a: assert property (p0_per_claim[5] == 1'b0 && p0_per_claim[13] == 1'b0
      && p0_per_claim[21] == 1'b0
      |=> p0_pad_oe[5] == $past(st_ff.p0_dir[5])
          && p0_pad_out[5] == $past(st_ff.p0_data[5]))
    else $error("port 0 gpio pad wrong");
  p1_gpio_a: assert property (!st_ff.p1_sel[6]
      |=> p1_pad_oe[6] == $past(st_ff.p1_dir[6]) && p1_pad_out[6] == $past(st_ff.p1_data[6]))
    else $error("port 1 gpio pad wrong");
  p2_dir_a: assert property (st_ff.p2_dir[5] == 1'b0 && st_ff.p2_sel[7] == 1'b0)
    else $error("unused bit became set");
  // mode 10 ranks timer 1 over serial 1 only, so the contest is serial 1 against timer 1
  p0_prec_a: assert property (st_ff.p2_dir[7:6] == 2'b10 && p0_per_claim[11]
      && p0_per_claim[19] && !p0_per_claim[3]
      |=> p0_pad_out[3] == $past(p0_per_out[19]))
    else $error("port 0 timer precedence wrong");
  pull_mode_a: assert property (st_ff.p0_mode[4] |=> !p0_pull_en[4])
    else $error("tristate pin still pulled");
  // polarity flop feeds the pin directly, so the new value shows one edge after the write
  pull_pol_a: assert property (reg_wr && reg_addr == pfd_pkg::ADDR_PULL_CFG
      |=> p0_pull_down == $past(reg_wdata[pfd_pkg::PULL_POL_BIT]))
    else $error("pull polarity not applied");
  dbg_a: assert property (dbg_active && dbg_drive |=> p2_pad_oe[1]
      && p2_pad_out[1] == $past(dbg_data_out))
    else $error("debug data pin not driven");
  // serial 1 wins pin 0: the pad must carry its drive, never serial 0's
  loser_a: assert property (st_ff.p1_sel[0] && p1_per_claim[0] && p1_per_claim[8]
      && !p1_per_claim[16] && !p1_per_claim[24] && st_ff.p2_sel[6]
      |=> p1_pad_oe[0] == $past(p1_per_oe[8]) && p1_pad_out[0] == $past(p1_per_out[8]))
    else $error("losing peripheral reached pad");

  dbg_c: cover property (dbg_active && dbg_drive);
  contest_c: cover property (st_ff.p1_sel[0] && p1_per_claim[0] && p1_per_claim[8]);
  read_c: cover property (reg_rd ##1 reg_rd);
  pin_c: cover property ($rose(p0_pin_level[0]));

endmodule
`default_nettype wire

// [test/pfd_pad_model.sv]
// pad model: resolves each package pin from the block's drive, pulls and the board
`timescale 1ns/10ps
`default_nettype none
module pfd_pad_model #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pull_en,
  input wire logic pull_down,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad_in
);
  // toggles every cycle so a floating pin never settles into a lucky value
  logic float_ff = 1'b0;

  // free-running float pattern
  always_ff @(posedge core_clk) begin
    float_ff <= ~float_ff;
  end

  // per pin: block drive wins, then pull resistor, then board, else floating
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pull_en[i]) begin
        pad_in[i] = ~pull_down;
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = float_ff;
      end
    end
  end
endmodule
`default_nettype wire

// [test/pfd_top_tb_top.sv]
// self-checking bench for the port function and direction block
`timescale 1ns/10ps
`default_nettype none
module pfd_top_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] p0_in, p1_in, p0_out, p0_oe, p1_out, p1_oe, p0_pull_en, p0_lvl;
  logic [4:0] p2_in, p2_out, p2_oe, p2_lvl;
  logic [7:0] p1_lvl, loc_cfg;
  logic p0_pull_down;
  logic [23:0] p0c = '0, p0o = '0, p0e = '0; // port 0 peripheral claim, out, enable
  logic [39:0] p1c = '0, p1o = '0, p1e = '0; // port 1 peripheral claim, out, enable
  logic [4:0] p2po = '0, p2pe = '0;
  logic dbg_act = 1'b0, dbg_drv = 1'b0, dbg_dat = 1'b0;
  logic [7:0] ext0_en = '0, ext0_val = '0, ext1_en = '0, ext1_val = '0; // board drive on pins
  logic [4:0] ext2_en = '0, ext2_val = '0;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [7:0] addrs [8] = '{8'h8f, 8'hf4, 8'hf5, 8'hfd, 8'hfe, 8'hff, 8'hf1, 8'hf7};
  logic [7:0] wmask [8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hdf, 8'h73, 8'h20};
  int pa [4] = '{0, 1, 2, 0}; // port 1 contest: first named slot
  int pb [4] = '{1, 3, 4, 2}; // port 1 contest: second named slot
  int pbit [4] = '{6, 5, 4, 3};
  int wa [4] = '{0, 1, 2, 2}; // port 0 mode winner slot
  int wb [4] = '{1, 0, 1, 0}; // port 0 mode loser slot

  // 4 ns clock
  always #2 core_clk = ~core_clk;

  pfd_top DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p0_pad_in(p0_in),
    .p1_pad_in(p1_in), .p2_pad_in(p2_in), .p0_pad_out(p0_out), .p0_pad_oe(p0_oe),
    .p1_pad_out(p1_out), .p1_pad_oe(p1_oe), .p2_pad_out(p2_out), .p2_pad_oe(p2_oe),
    .p0_pull_en(p0_pull_en), .p0_pull_down(p0_pull_down), .p0_pin_level(p0_lvl),
    .p1_pin_level(p1_lvl), .p2_pin_level(p2_lvl), .peripheral_location_config(loc_cfg),
    .p0_per_claim(p0c), .p0_per_out(p0o), .p0_per_oe(p0e), .p1_per_claim(p1c),
    .p1_per_out(p1o), .p1_per_oe(p1e), .p2_per_out(p2po), .p2_per_oe(p2pe),
    .dbg_active(dbg_act), .dbg_drive(dbg_drv), .dbg_data_out(dbg_dat));

  // port 0 is the only port with pulls in this block
  pfd_pad_model #(.W(8)) pads0 (.core_clk(core_clk), .pad_out(p0_out), .pad_oe(p0_oe),
    .pull_en(p0_pull_en), .pull_down(p0_pull_down), .ext_en(ext0_en), .ext_val(ext0_val),
    .pad_in(p0_in));
  pfd_pad_model #(.W(8)) pads1 (.core_clk(core_clk), .pad_out(p1_out), .pad_oe(p1_oe),
    .pull_en(8'h00), .pull_down(1'b0), .ext_en(ext1_en), .ext_val(ext1_val), .pad_in(p1_in));
  pfd_pad_model #(.W(5)) pads2 (.core_clk(core_clk), .pad_out(p2_out), .pad_oe(p2_oe),
    .pull_en(5'h00), .pull_down(1'b0), .ext_en(ext2_en), .ext_val(ext2_val), .pad_in(p2_in));

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  // one comparison, four-state exact
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // single-cycle read strobe; data taken in the following cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // let registered pad outputs settle
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    // reset state, then all-ones write with reserved bits reading zero
    chk(p0_oe, 8'h00);
    chk(p1_oe, 8'h00);
    chk(p0_pull_en, 8'hff);
    for (int i = 0; i < 8; i++) begin
      rd_reg(addrs[i], rv);
      chk(rv, 8'h00);
      wr_reg(addrs[i], 8'hff);
      rd_reg(addrs[i], rv);
      chk(rv, wmask[i]);
      wr_reg(addrs[i], 8'h00);
    end
    // location config reaches the peripherals with reserved bits dropped
    wr_reg(8'hf1, 8'hff);
    settle();
    chk(loc_cfg, 8'h73);
    wr_reg(8'hf1, 8'h00);
    wr_reg(8'h81, 8'hff);
    rd_reg(8'h81, rv);
    chk(rv, 8'h00);
    $display("test registers done");
    // port 0 gpio outputs, then input mode and pull polarity
    wr_reg(8'h80, 8'ha5);
    wr_reg(8'hfd, 8'hff);
    settle();
    chk(p0_out, 8'ha5);
    chk(p0_oe, 8'hff);
    chk(p0_pull_en, 8'h00);
    wr_reg(8'hfd, 8'h00);
    wr_reg(8'h8f, 8'h0f);
    wr_reg(8'hf7, 8'h20);
    repeat (6) @(posedge core_clk);
    #1;
    chk(p0_pull_en, 8'hf0);
    chk({7'h00, p0_pull_down}, 8'h01);
    chk(p0_lvl & 8'hf0, 8'h00);
    // port 1 mixed direction: outputs read back latch, inputs the board level
    ext0_en <= 8'h0f;
    ext0_val <= 8'h05;
    ext1_en <= 8'h0f;
    ext1_val <= 8'h3c;
    wr_reg(8'hfe, 8'hf0);
    repeat (8) @(posedge core_clk);
    rd_reg(8'h90, rv);
    chk(rv, 8'hfc);
    chk(p1_lvl, 8'hfc);
    chk(p0_lvl, 8'h05);
    ext0_en <= 8'h00;
    ext1_en <= 8'h00;
    $display("test gpio done");
    // port 1 pairwise contests, each precedence bit both ways
    wr_reg(8'hfe, 8'h00);
    wr_reg(8'hf4, 8'hff);
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge core_clk);
        // contest i sits on pin i, so each pairwise check sees its own pin
        p1c <= (40'h1 << (pa[i] * 8 + i)) | (40'h1 << (pb[i] * 8 + i));
        p1o <= 40'h1 << (pa[i] * 8 + i);
        p1e <= 40'h1 << (pa[i] * 8 + i);
        wr_reg(8'hf5, 8'(v << pbit[i]));
        settle();
        chk({6'h00, p1_oe[i], p1_out[i]}, v ? 8'h00 : 8'h03);
      end
    end
    // select zero hands the pin back to gpio even while claimed
    wr_reg(8'hf4, 8'h00);
    settle();
    chk({6'h00, p1_oe[3], p1_out[3]}, 8'h01);
    @(posedge core_clk);
    p1c <= '0;
    $display("test port 1 precedence done");
    // port 0 precedence modes, both contenders driving opposite values
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      p0c <= (24'h8 << (wa[m] * 8)) | (24'h8 << (wb[m] * 8));
      p0o <= 24'h8 << (wa[m] * 8);
      p0e <= (24'h8 << (wa[m] * 8)) | (24'h8 << (wb[m] * 8));
      wr_reg(8'hff, 8'(m << 6));
      settle();
      chk({6'h00, p0_oe[3], p0_out[3]}, 8'h03);
    end
    @(posedge core_clk);
    p0c <= '0;
    $display("test port 0 precedence done");
    // port 2: peripheral on pin 0, debug owning pins 1 and 2
    p2po <= 5'h01;
    p2pe <= 5'h01;
    dbg_act <= 1'b1;
    dbg_drv <= 1'b1;
    dbg_dat <= 1'b1;
    wr_reg(8'hff, 8'h07);
    wr_reg(8'hf5, 8'h01);
    settle();
    chk({3'h0, p2_oe}, 8'h03);
    chk({6'h00, p2_out[1:0]}, 8'h03);
    @(posedge core_clk);
    dbg_drv <= 1'b0;
    settle();
    chk({3'h0, p2_oe}, 8'h01);
    @(posedge core_clk);
    dbg_act <= 1'b0;
    settle();
    chk({3'h0, p2_oe}, 8'h07);
    wr_reg(8'hf5, 8'h00);
    wr_reg(8'hff, 8'h00);
    settle();
    chk({3'h0, p2_oe}, 8'h00);
    // port 2 inputs driven by the board: data read and settled level
    ext2_en <= 5'h1f;
    ext2_val <= 5'h15;
    repeat (6) @(posedge core_clk);
    rd_reg(8'ha0, rv);
    chk(rv, 8'h15);
    chk({3'h0, p2_lvl}, 8'h15);
    $display("test port 2 done");
    finish_test();
  end
endmodule
`default_nettype wire
